// *** ulp_front_model.sv ***
// Current source model: three phase phasors built from per-phase magnitudes.
// Assumes Q12 magnitudes; rev gives reversed phase rotation. Outputs change after a rising edge.
`timescale 1ns/10ps
module ulp_front_model (
    input  wire logic               sys_clk,
    input  wire logic        [15:0] mag_a,
    input  wire logic        [15:0] mag_b,
    input  wire logic        [15:0] mag_c,
    input  wire logic               rev,
    output logic signed      [15:0] ia_re,
    output logic signed      [15:0] ia_im,
    output logic signed      [15:0] ib_re,
    output logic signed      [15:0] ib_im,
    output logic signed      [15:0] ic_re,
    output logic signed      [15:0] ic_im
);
    // Scales by sin 120 degrees in Q15
    function automatic logic signed [15:0] sn(input logic [15:0] m);
        return 16'((32'(m) * 32'h6ed9) >> 15);
    endfunction
    always @(posedge sys_clk) begin
        ia_re <= $signed(mag_a);
        ia_im <= 16'h0;
        ib_re <= -(mag_b >> 1);
        ib_im <= rev ? sn(mag_b) : -sn(mag_b);
        ic_re <= -(mag_c >> 1);
        ic_im <= rev ? -sn(mag_c) : sn(mag_c);
    end
endmodule

// *** ulp_pkg.sv ***
// Constants for the unbalanced load protection element: register map, control bits, reset values, timing.
// Assumes a 50 MHz system clock and phase currents scaled so that nominal current equals 2**12.
package ulp_pkg;
    // Register byte offsets
    localparam logic [7:0] ULP_OFF_CTRL     = 8'h00;
    localparam logic [7:0] ULP_OFF_THRESH   = 8'h04;
    localparam logic [7:0] ULP_OFF_FLA      = 8'h08;
    localparam logic [7:0] ULP_OFF_PICKUP   = 8'h0c;
    localparam logic [7:0] ULP_OFF_DELAY    = 8'h10;
    localparam logic [7:0] ULP_OFF_KCAP     = 8'h14;
    localparam logic [7:0] ULP_OFF_COOL     = 8'h18;
    localparam logic [7:0] ULP_OFF_STATUS   = 8'h1c;
    localparam logic [7:0] ULP_OFF_INT_STAT = 8'h20;
    localparam logic [7:0] ULP_OFF_INT_MASK = 8'h24;

    // Control register bit positions
    localparam int ULP_CTRL_ENABLE   = 0;
    localparam int ULP_CTRL_INVERSE  = 1;
    localparam int ULP_CTRL_RATIO_EN = 2;
    localparam int ULP_CTRL_ROT_ACB  = 3;
    localparam int ULP_CTRL_REL_FLA  = 4;
    localparam int ULP_CTRL_PRESET   = 8;
    localparam int ULP_CTRL_W        = 5;

    // Status and interrupt bit positions
    localparam int ULP_ST_TRIP    = 0;
    localparam int ULP_ST_PICKUP  = 1;
    localparam int ULP_ST_HEATING = 2;
    localparam int ULP_EV_W       = 2;

    // Reset values
    localparam logic [ULP_CTRL_W-1:0] ULP_RST_CTRL = 5'h00;
    localparam logic [15:0] ULP_RST_THRESH = 16'h0199;
    localparam logic [15:0] ULP_RST_FLA    = 16'h0100;
    localparam logic [7:0]  ULP_RST_PICKUP = 8'h14;
    localparam logic [15:0] ULP_RST_DELAY  = 16'h03e8;
    localparam logic [15:0] ULP_RST_KCAP   = 16'h000a;
    localparam logic [15:0] ULP_RST_COOL   = 16'h0002;
    localparam logic [ULP_EV_W-1:0] ULP_RST_MASK = 2'h0;

    // Scaling
    localparam int ULP_IN_FRAC = 12;
    localparam int ULP_FLA_FRAC = 8;
    localparam int ULP_COOL_FRAC = 16;
    localparam logic [17:0] ULP_SQRT3_HALF = 18'h06eda;

    // Evaluation tick
    localparam int ULP_CLK_HZ   = 50_000_000;
    localparam int ULP_TICK_US  = 1000;
    localparam int ULP_TICK_CYC = (ULP_CLK_HZ / 1_000_000) * ULP_TICK_US;
    localparam int ULP_TICKS_PER_S = 1_000_000 / ULP_TICK_US;

    localparam logic [1:0] ULP_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ULP_RESP_SLVERR = 2'h2;
endpackage

// *** ulp_top.sv ***
// Unbalanced load protection element with AXI4-Lite register slave and level interrupt.
// Phase current phasors arrive from the measurement front end on sys_clk; resetn is asynchronous.
// How it works
// - Sequence currents from phases, honouring phase rotation.
// - Negative-sequence threshold below which nothing operates.
// - Optional percent ratio check of negative/positive.
// - Definite-time trip needs combined condition for full delay.
// - Threshold expressed in multiples of nominal current.
// - Definite time uses the set delay.
// - Inverse time computes its own delay.
// - Thermal energy updates always, trip or not.
// - Inverse trip also needs energy at or above limit.
// - Cold delay is capability over squared difference.
// - Residual heat shortens the inverse delay.
// - Heating integrates squared current minus squared threshold.
// - Heating starts from energy left by cooling.
// - Cooling decays energy exponentially by time constant.
// - Energy below one percent limit clears.
// - Thermal energy is never visible outside.
// - Identical parameterised structure for every instance.
// - Protection reset clears element and timers instantly.
`timescale 1ns/10ps
module ulp_top
    import ulp_pkg::*;
#(
    parameter int PH_W     = 16,
    parameter int TICK_CYC = ULP_TICK_CYC
) (
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic signed [PH_W-1:0] ia_re,
    input  wire logic signed [PH_W-1:0] ia_im,
    input  wire logic signed [PH_W-1:0] ib_re,
    input  wire logic signed [PH_W-1:0] ib_im,
    input  wire logic signed [PH_W-1:0] ic_re,
    input  wire logic signed [PH_W-1:0] ic_im,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    output logic [1:0]                 s_axi_bresp,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    input  wire logic [7:0]            s_axi_araddr,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       trip,
    output logic                       irq
);
    // One parameterised element, replicated per instance
    if (PH_W != 16) begin : g_chk_w
        $error("ulp_top supports PH_W of 16 only");
    end
    if (TICK_CYC < 2 || TICK_CYC > 32'h7fffffff) begin : g_chk_t
        $error("ulp_top TICK_CYC out of range");
    end

    localparam int SW = 20;
    localparam int MW = 40;
    localparam int TW = 60;

    typedef struct packed {
        logic                  aw_have;
        logic                  w_have;
        logic [7:0]            aw_addr;
        logic [31:0]           w_data;
        logic [3:0]            w_strb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [1:0]            rresp;
        logic [31:0]           rdata;
        logic [ULP_CTRL_W-1:0] ctrl;
        logic [15:0]           thresh;
        logic [15:0]           fla;
        logic [7:0]            pickup;
        logic [15:0]           delay;
        logic [15:0]           kcap;
        logic [15:0]           cool;
        logic [ULP_EV_W-1:0]   int_stat;
        logic [ULP_EV_W-1:0]   int_mask;
        logic [31:0]           tick_cnt;
        logic                  tick;
        logic [MW-1:0]         mag1sq;
        logic [MW-1:0]         mag2sq;
        logic [TW-1:0]         theta;
        logic [15:0]           dcnt;
        logic                  pickup_st;
        logic                  trip;
    } ulp_state_t;

    ulp_state_t st_q;
    ulp_state_t st_d;
    logic       rst_meta_q;
    logic       rst_n_q;

    // Reset release through two flip-flops
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end
    // Multiply by sqrt(3)/2 in Q15
    function automatic logic signed [SW-1:0] mul_c(input logic signed [PH_W-1:0] v);
        logic signed [PH_W+18:0] p;
        p = v * $signed({1'b0, ULP_SQRT3_HALF});
        return SW'(p >>> 15);
    endfunction
    // Rotate phasor by a (sq=0) or a squared (sq=1); returns {re, im}
    function automatic logic [2*SW-1:0] rot(input logic signed [PH_W-1:0] x,
                                            input logic signed [PH_W-1:0] y,
                                            input logic                  sq);
        logic signed [SW-1:0] hx;
        logic signed [SW-1:0] hy;
        logic signed [SW-1:0] re;
        logic signed [SW-1:0] im;
        hx = SW'(x) >>> 1;
        hy = SW'(y) >>> 1;
        re = sq ? (mul_c(y) - hx) : (-hx - mul_c(y));
        im = sq ? (-mul_c(x) - hy) : (mul_c(x) - hy);
        return {re, im};
    endfunction
    function automatic logic [MW-1:0] magsq(input logic signed [SW-1:0] re, input logic signed [SW-1:0] im);
        return MW'(re * re) + MW'(im * im);
    endfunction
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    logic [2*SW-1:0]      b_a, b_a2, c_a, c_a2;
    logic signed [SW-1:0] p_re, p_im, n_re, n_im;
    logic [15:0]          thr_eff;
    logic [MW-1:0]        thr9sq;
    logic                 heat;
    logic                 ratio_ok;
    logic                 cond;
    logic [TW-1:0]        theta_max;
    logic [TW-1:0]        cool_dec;
    logic [TW+15:0]       cool_prod;
    logic [31:0]          rd_val;
    logic                 rd_hit;
    logic                 wr_hit;
    logic                 wr_go;
    logic                 preset;
    logic [ULP_EV_W-1:0]  ev;

    always_comb begin
        // Three times the sequence components; rotation setting swaps them
        b_a  = rot(ib_re, ib_im, 1'b0);
        b_a2 = rot(ib_re, ib_im, 1'b1);
        c_a  = rot(ic_re, ic_im, 1'b0);
        c_a2 = rot(ic_re, ic_im, 1'b1);
        p_re = SW'(ia_re) + b_a[2*SW-1:SW] + c_a2[2*SW-1:SW];
        p_im = SW'(ia_im) + b_a[SW-1:0] + c_a2[SW-1:0];
        n_re = SW'(ia_re) + b_a2[2*SW-1:SW] + c_a[2*SW-1:SW];
        n_im = SW'(ia_im) + b_a2[SW-1:0] + c_a[SW-1:0];
        // Threshold in units of In, optionally scaled from full load
        thr_eff = st_q.ctrl[ULP_CTRL_REL_FLA]
                ? 16'((32'(st_q.thresh) * 32'(st_q.fla)) >> ULP_FLA_FRAC) : st_q.thresh;
        thr9sq = MW'(9) * MW'(32'(thr_eff) * 32'(thr_eff));
        // Strictly above threshold heats; equal cools
        heat = st_q.mag2sq > thr9sq;
        // 100*I2 > pickup*I1 compared on squares
        ratio_ok = (64'(st_q.mag2sq) * 64'd10000) > (64'(st_q.mag1sq) * 64'(16'(st_q.pickup) * 16'(st_q.pickup)));
        cond = heat && (!st_q.ctrl[ULP_CTRL_RATIO_EN] || ratio_ok);
        // Limit = K * ticks/s * (9 * In^2) so cold delay is K/(I2^2 - thr^2)
        theta_max = TW'(64'(st_q.kcap) * 64'(9 * ULP_TICKS_PER_S)) << (2 * ULP_IN_FRAC);
        cool_prod = (TW+16)'(st_q.theta) * (TW+16)'(st_q.cool);
        cool_dec = TW'(cool_prod >> ULP_COOL_FRAC);
        if (cool_dec == '0 && st_q.theta != '0) begin
            cool_dec = TW'(1);
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            ULP_OFF_CTRL:     rd_val = 32'(st_q.ctrl);
            ULP_OFF_THRESH:   rd_val = 32'(st_q.thresh);
            ULP_OFF_FLA:      rd_val = 32'(st_q.fla);
            ULP_OFF_PICKUP:   rd_val = 32'(st_q.pickup);
            ULP_OFF_DELAY:    rd_val = 32'(st_q.delay);
            ULP_OFF_KCAP:     rd_val = 32'(st_q.kcap);
            ULP_OFF_COOL:     rd_val = 32'(st_q.cool);
            // Status shows flags only, never the energy
            ULP_OFF_STATUS:   rd_val = 32'({heat, st_q.pickup_st, st_q.trip});
            ULP_OFF_INT_STAT: rd_val = 32'(st_q.int_stat);
            ULP_OFF_INT_MASK: rd_val = 32'(st_q.int_mask);
            default: begin
                rd_val = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
        case (st_q.aw_addr)
            ULP_OFF_CTRL, ULP_OFF_THRESH, ULP_OFF_FLA, ULP_OFF_PICKUP, ULP_OFF_DELAY,
            ULP_OFF_KCAP, ULP_OFF_COOL, ULP_OFF_INT_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_comb begin
        st_d = st_q;
        wr_go = st_q.aw_have && st_q.w_have && !st_q.bvalid;
        preset = wr_go && st_q.aw_addr == ULP_OFF_CTRL && st_q.w_strb[1]
               && st_q.w_data[ULP_CTRL_PRESET];

        // Write channel: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_d.aw_have = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_d.w_have = 1'b1;
            st_d.w_data = s_axi_wdata;
            st_d.w_strb = s_axi_wstrb;
        end
        if (wr_go) begin
            st_d.aw_have = 1'b0;
            st_d.w_have = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = wr_hit ? ULP_RESP_OKAY : ULP_RESP_SLVERR;
            case (st_q.aw_addr)
                ULP_OFF_CTRL:     st_d.ctrl = ULP_CTRL_W'(merge(32'(st_q.ctrl), st_q.w_data, st_q.w_strb));
                ULP_OFF_THRESH:   st_d.thresh = 16'(merge(32'(st_q.thresh), st_q.w_data, st_q.w_strb));
                ULP_OFF_FLA:      st_d.fla = 16'(merge(32'(st_q.fla), st_q.w_data, st_q.w_strb));
                ULP_OFF_PICKUP:   st_d.pickup = 8'(merge(32'(st_q.pickup), st_q.w_data, st_q.w_strb));
                ULP_OFF_DELAY:    st_d.delay = 16'(merge(32'(st_q.delay), st_q.w_data, st_q.w_strb));
                ULP_OFF_KCAP:     st_d.kcap = 16'(merge(32'(st_q.kcap), st_q.w_data, st_q.w_strb));
                ULP_OFF_COOL:     st_d.cool = 16'(merge(32'(st_q.cool), st_q.w_data, st_q.w_strb));
                ULP_OFF_INT_MASK: st_d.int_mask = ULP_EV_W'(merge(32'(st_q.int_mask), st_q.w_data, st_q.w_strb));
                default: ;
            endcase
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end

        // Read channel
        ev = '0;
        if (s_axi_arvalid && s_axi_arready) begin
            st_d.rvalid = 1'b1;
            st_d.rdata = rd_val;
            st_d.rresp = rd_hit ? ULP_RESP_OKAY : ULP_RESP_SLVERR;
        end
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end

        st_d.tick = 1'b0;
        if (st_q.tick_cnt == 32'(TICK_CYC - 1)) begin
            st_d.tick_cnt = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.tick_cnt = st_q.tick_cnt + 32'd1;
        end
        st_d.mag1sq = st_q.ctrl[ULP_CTRL_ROT_ACB] ? magsq(n_re, n_im) : magsq(p_re, p_im);
        st_d.mag2sq = st_q.ctrl[ULP_CTRL_ROT_ACB] ? magsq(p_re, p_im) : magsq(n_re, n_im);

        if (st_q.tick) begin
            // Thermal model runs regardless of enable or trip
            if (heat) begin
                st_d.theta = st_q.theta + TW'(st_q.mag2sq - thr9sq);
            end else if (TW'(64'(st_q.theta) * 64'd100) < theta_max
                         || st_q.theta < cool_dec) begin
                st_d.theta = '0;
            end else begin
                st_d.theta = st_q.theta - cool_dec;
            end
            st_d.pickup_st = cond && st_q.ctrl[ULP_CTRL_ENABLE];
            if (cond) begin
                if (st_q.dcnt != 16'hffff) begin
                    st_d.dcnt = st_q.dcnt + 16'd1;
                end
            end else begin
                st_d.dcnt = '0;
            end
            if (st_q.ctrl[ULP_CTRL_INVERSE]) begin
                st_d.trip = st_q.ctrl[ULP_CTRL_ENABLE] && cond && st_q.theta >= theta_max;
            end else begin
                st_d.trip = st_q.ctrl[ULP_CTRL_ENABLE] && cond && st_q.dcnt >= st_q.delay;
            end
        end
        ev[ULP_ST_TRIP] = st_d.trip && !st_q.trip;
        ev[ULP_ST_PICKUP] = st_d.pickup_st && !st_q.pickup_st;

        // Protection reset clears energy, timers, trip and pickup at once
        if (preset) begin
            st_d.theta = '0;
            st_d.dcnt = '0;
            st_d.trip = 1'b0;
            st_d.pickup_st = 1'b0;
            ev = '0;
        end

        // Sticky events, cleared by reading; a new event wins
        if (s_axi_arvalid && s_axi_arready && s_axi_araddr == ULP_OFF_INT_STAT) begin
            st_d.int_stat = ev;
        end else begin
            st_d.int_stat = st_q.int_stat | ev;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= '0;
            st_q.ctrl <= ULP_RST_CTRL;
            st_q.thresh <= ULP_RST_THRESH;
            st_q.fla <= ULP_RST_FLA;
            st_q.pickup <= ULP_RST_PICKUP;
            st_q.delay <= ULP_RST_DELAY;
            st_q.kcap <= ULP_RST_KCAP;
            st_q.cool <= ULP_RST_COOL;
            st_q.int_mask <= ULP_RST_MASK;
        end else begin
            st_q <= st_d;
        end
    end

    assign s_axi_awready = !st_q.aw_have && !st_q.bvalid;
    assign s_axi_wready  = !st_q.w_have && !st_q.bvalid;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_arready = !st_q.rvalid;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rdata   = st_q.rdata;
    assign s_axi_rresp   = st_q.rresp;
    assign trip          = st_q.trip;
    assign irq           = |(st_q.int_stat & st_q.int_mask);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n_q);
    property p_trip_cond;
        trip |-> st_q.ctrl[ULP_CTRL_ENABLE] && st_q.pickup_st;
    endproperty
    a_trip_cond: assert property (p_trip_cond) else $error("trip without pickup");
    property p_thr_floor;
        st_q.tick && !heat && !preset |=> !trip;
    endproperty
    a_thr_floor: assert property (p_thr_floor) else $error("trip at or below threshold");
    property p_ratio;
        st_q.tick && st_q.ctrl[ULP_CTRL_RATIO_EN] && !ratio_ok |=> !trip;
    endproperty
    a_ratio: assert property (p_ratio) else $error("trip with ratio below pickup");
    property p_definite_time;
        st_q.tick && !preset && !st_q.ctrl[ULP_CTRL_INVERSE] && st_q.ctrl[ULP_CTRL_ENABLE] && cond
            && st_q.dcnt >= st_q.delay |=> trip;
    endproperty
    a_definite_time: assert property (p_definite_time) else $error("definite delay elapsed without trip");
    property p_inv;
        st_q.tick && st_q.ctrl[ULP_CTRL_INVERSE] && st_q.theta < theta_max |=> !trip;
    endproperty
    a_inv: assert property (p_inv) else $error("inverse trip below energy limit");
    property p_heat;
        st_q.tick && heat && !preset |=> st_q.theta > $past(st_q.theta);
    endproperty
    a_heat: assert property (p_heat) else $error("energy not rising while heating");
    property p_cool;
        st_q.tick && !heat && st_q.theta != '0 |=> st_q.theta < $past(st_q.theta);
    endproperty
    a_cool: assert property (p_cool) else $error("energy not falling while cooling");
    property p_floor;
        st_q.tick && !heat && TW'(64'(st_q.theta) * 64'd100) < theta_max |=> st_q.theta == '0;
    endproperty
    a_floor: assert property (p_floor) else $error("small energy not cleared");
    property p_hold;
        !st_q.tick && !preset |=> $stable(st_q.theta) && $stable(trip);
    endproperty
    a_hold: assert property (p_hold) else $error("state changed off tick");
    property p_preset;
        preset |=> st_q.theta == '0 && !trip && st_q.dcnt == '0;
    endproperty
    a_preset: assert property (p_preset) else $error("protection reset incomplete");
    c_definite_time_trip: cover property (st_q.tick && !st_q.ctrl[ULP_CTRL_INVERSE] ##1 $rose(trip));
    c_inv_trip: cover property (st_q.tick && st_q.ctrl[ULP_CTRL_INVERSE] ##1 $rose(trip));
    c_cool_zero: cover property (st_q.tick && !heat && st_q.theta != '0 ##1 st_q.theta == '0);
    c_irq: cover property ($rose(irq));
endmodule

// *** ulp_top_test.sv ***
// Self-checking bench for ulp_top: AXI4-Lite master tasks and a current source model.
// Assumes a short evaluation tick of T cycles so that delays stay brief.
`timescale 1ns/10ps
module ulp_top_test;
    import ulp_pkg::*;
    localparam int T  = 50;
    localparam int D  = 4;
    localparam int DL = (D - 1) * T;
    localparam int DH = (D + 2) * T + 5;
    localparam logic [15:0] IN = 16'h1000;
    localparam logic [15:0] HI = 16'h4000;
    logic               sys_clk = 1'h0;
    logic               resetn = 1'h0;
    logic               rev = 1'h0;
    logic        [15:0] mag_a = '0, mag_b = '0, mag_c = '0;
    logic signed [15:0] ia_re, ia_im, ib_re, ib_im, ic_re, ic_im;
    logic               s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic               s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic        [31:0] s_axi_wdata = '0;
    logic        [3:0]  s_axi_wstrb = '0;
    logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, trip, irq;
    logic        [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        [31:0] s_axi_rdata, d;
    int                 n_fail = 0, checks_done = 0, cyc = 0, n;

    always #10 sys_clk = ~sys_clk;

    ulp_front_model src_model (.sys_clk, .mag_a, .mag_b, .mag_c, .rev, .ia_re, .ia_im, .ib_re, .ib_im, .ic_re, .ic_im);
    ulp_top #(.TICK_CYC(T)) uut (
        .sys_clk, .resetn, .ia_re, .ia_im, .ib_re, .ib_im, .ic_re, .ic_im,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
        .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .trip, .irq);

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            conclude();
        end
    end

    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(negedge sys_clk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            @(posedge sys_clk);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
        end while ((s_axi_awvalid && !aw) || (s_axi_wvalid && !w));
        do @(negedge sys_clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        @(posedge sys_clk);
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(negedge sys_clk); while (!s_axi_arready);
        @(posedge sys_clk);
        s_axi_arvalid <= 1'h0;
        do @(negedge sys_clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge sys_clk);
        s_axi_rready <= 1'h0;
    endtask

    task automatic src(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c, input logic v);
        @(posedge sys_clk);
        mag_a <= a;
        mag_b <= b;
        mag_c <= c;
        rev <= v;
    endtask

    // Waits for trip and judges the cycle count against lo..hi
    task automatic trip_in(input string s, input int lo, input int hi);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (trip !== 1'h1 && n < hi + T);
        chk(s, 32'h1, 32'(n > lo && n <= hi));
    endtask

    task automatic quiet(input string s, input int k);
        repeat (k * T) @(negedge sys_clk);
        chk(s, 32'h0, 32'(trip));
    endtask

    task automatic t_regs();
        logic [7:0]  o[8] = '{ULP_OFF_CTRL, ULP_OFF_THRESH, ULP_OFF_FLA, ULP_OFF_PICKUP, ULP_OFF_DELAY,
                              ULP_OFF_KCAP, ULP_OFF_COOL, ULP_OFF_INT_MASK};
        logic [31:0] e[8] = '{ULP_RST_CTRL, ULP_RST_THRESH, ULP_RST_FLA, ULP_RST_PICKUP, ULP_RST_DELAY,
                              ULP_RST_KCAP, ULP_RST_COOL, ULP_RST_MASK};
        for (int i = 0; i < 8; i++) begin
            rd(o[i]);
            chk("reset value", e[i], d);
            chk("mapped rresp", ULP_RESP_OKAY, r);
        end
        rd(8'h40);
        chk("unmapped rdata", 32'h0, d);
        chk("unmapped rresp", ULP_RESP_SLVERR, r);
        wr(ULP_OFF_STATUS, 32'h1);
        chk("read-only bresp", ULP_RESP_SLVERR, r);
        $display("test regs done");
    endtask

    task automatic t_def();
        wr(ULP_OFF_DELAY, D);
        chk("write bresp", ULP_RESP_OKAY, r);
        wr(ULP_OFF_CTRL, 32'h1);
        src(16'h0ccd, IN, IN, 1'h0);
        quiet("below threshold", D + 3);
        src(16'h099a, IN, IN, 1'h0);
        trip_in("definite delay", DL, DH);
        rd(ULP_OFF_STATUS);
        chk("status flags", 32'h7, d);
        chk("irq masked", 32'h0, 32'(irq));
        wr(ULP_OFF_INT_MASK, 32'h1);
        @(negedge sys_clk);
        chk("irq", 32'h1, 32'(irq));
        rd(ULP_OFF_INT_STAT);
        chk("events", 32'h3, d);
        @(negedge sys_clk);
        chk("irq cleared", 32'h0, 32'(irq));
        wr(ULP_OFF_CTRL, 32'h101);
        @(negedge sys_clk);
        chk("reset clears trip", 32'h0, 32'(trip));
        trip_in("timer restarts", DL, DH);
        src(IN, IN, IN, 1'h0);
        quiet("trip drops", 3);
        wr(ULP_OFF_FLA, 32'h200);
        wr(ULP_OFF_CTRL, 32'h111);
        src(16'h099a, IN, IN, 1'h0);
        quiet("relative threshold", D + 3);
        wr(ULP_OFF_INT_MASK, 32'h0);
        rd(ULP_OFF_INT_STAT);
        $display("test definite done");
    endtask

    task automatic t_rot();
        wr(ULP_OFF_CTRL, 32'h109);
        trip_in("acb forward", DL, DH);
        src(IN, IN, IN, 1'h1);
        quiet("acb reversed", 3);
        wr(ULP_OFF_CTRL, 32'h101);
        trip_in("abc reversed", DL, DH);
        $display("test rotation done");
    endtask

    task automatic t_ratio();
        wr(ULP_OFF_THRESH, 32'h29);
        src(16'h1800, IN, IN, 1'h0);
        wr(ULP_OFF_CTRL, 32'h105);
        quiet("ratio below pickup", D + 3);
        wr(ULP_OFF_CTRL, 32'h101);
        trip_in("ratio off", DL, DH);
        src(16'h0, IN, IN, 1'h0);
        wr(ULP_OFF_CTRL, 32'h105);
        trip_in("ratio above pickup", DL, DH);
        $display("test ratio done");
    endtask

    task automatic t_inv();
        src(IN, IN, IN, 1'h0);
        wr(ULP_OFF_KCAP, 32'h1);
        wr(ULP_OFF_CTRL, 32'h103);
        src(HI, HI, HI, 1'h1);
        trip_in("cold inverse", 60 * T, 66 * T);
        src(IN, IN, IN, 1'h0);
        quiet("inverse drops", 5);
        src(HI, HI, HI, 1'h1);
        trip_in("warm inverse", 0, 3 * T);
        wr(ULP_OFF_COOL, 32'h8000);
        src(IN, IN, IN, 1'h0);
        quiet("cooling", 12);
        src(HI, HI, HI, 1'h1);
        trip_in("cooled inverse", 40 * T, 66 * T);
        $display("test inverse done");
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'h1;
        repeat (4) @(posedge sys_clk);
        t_regs();
        t_def();
        t_rot();
        t_ratio();
        t_inv();
        conclude();
    end
endmodule
